//--- usu_shift_clock.sv
// clock source selection, shift register, counter and pin routing
//
// Notes on behaviour
// - external clock: output changes on opposite edge
// - strobe or timer source: output latch transparent
// - source 00: strobe bit clocks both, else none
// - source 01: timer match clocks both
// - external: shift on rise, or fall if low bit
// - external, strobe bit 0: counter on both edges
// - external, strobe bit 1: toggle writes clock counter
// - software strobe: shift once, count once
// - strobe shifts in input sampled cycle before
// - strobe and toggle bits read as zero
// - toggle inverts clock port; direction gates pin
// - pin position picks port B or port A group
// - pin position upper seven bits read zero
// - wire mode touches outputs only, never inputs
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`include "usu_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module usu_shift_clock
  import usu_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int CNT_W  = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        link_clk,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timer_match,
  input  wire logic [2:0]  pa_in,
  input  wire logic [2:0]  pb_in,
  output logic      [2:0]  pa_out,
  output logic      [2:0]  pa_oe,
  output logic      [2:0]  pb_out,
  output logic      [2:0]  pb_oe
);

  // ---------------- register state ----------------
  logic [1:0]        clk_src_sel_q;   // clock source field
  logic              clk_strobe_q;    // counter select in external mode
  logic [1:0]        wire_mode_sel_q; // output stage mode
  logic              clk_dir_q;       // clock pin direction, 1 = output
  logic              do_dir_q;        // data pin direction, 1 = output
  logic              pin_pos_sel_q;   // 0 = port B group, 1 = port A group
  logic [DATA_W-1:0] data_q;          // shift register
  logic [CNT_W-1:0]  count_q;         // transfer counter
  logic              ovf_q;           // sticky counter wrap flag
  logic              clk_port_q;      // clock port value driven by toggle
  logic              out_latch_q;     // output latch for external clocking
  logic              din_prev_q;      // data input one cycle ago
  logic              ack_q;           // bus acknowledge

  // ---------------- bus decode ----------------
  logic wb_req;    // request present
  logic wr_en;     // write takes effect this edge
  logic wr_ctrl;   // control register written
  logic wr_data;   // data register written
  logic wr_count;  // count register written
  logic wr_pinpos; // pin position register written
  logic [7:0] wbyte; // written byte lane 0

  assign wb_req    = wb_cyc_i & wb_stb_i;
  assign wr_en     = wb_req & wb_we_i & ack_q & wb_sel_i[0];
  assign wbyte     = wb_dat_i[7:0];
  assign wr_ctrl   = wr_en & (wb_adr_i == `USU_OFS_CTRL);
  assign wr_data   = wr_en & (wb_adr_i == `USU_OFS_DATA);
  assign wr_count  = wr_en & (wb_adr_i == `USU_OFS_COUNT);
  assign wr_pinpos = wr_en & (wb_adr_i == `USU_OFS_PINPOS);
  assign wb_ack_o  = ack_q;

  // decode of the source field, used for shift, counter and latch
  function automatic usu_src_type src_decode(input logic [1:0] f);
    usu_src_type s;
    s = USU_SRC_NONE;
    case (f)
      2'b00:   s = USU_SRC_SOFT;
      2'b01:   s = USU_SRC_TIMER;
      2'b10:   s = USU_SRC_EXT_POS;
      2'b11:   s = USU_SRC_EXT_NEG;
      default: s = USU_SRC_NONE;
    endcase
    return s;
  endfunction : src_decode

  usu_src_type src;   // decoded source
  logic        ext;   // an external edge drives the shift register
  assign src = src_decode(clk_src_sel_q);
  assign ext = (src == USU_SRC_EXT_POS) || (src == USU_SRC_EXT_NEG);

  // write strobes; both bits are pulses, never stored for readback
  logic strobe_wr;  // one written to the strobe bit
  logic toggle_wr;  // one written to the toggle bit
  assign strobe_wr = wr_ctrl & wbyte[`USU_CTRL_STROBE];
  assign toggle_wr = wr_ctrl & wbyte[`USU_CTRL_TOGGLE];

  // ---------------- link capture and crossing ----------------
  logic       pos_tgl;    // toggles on each rising serial clock edge
  logic       neg_tgl;    // toggles on each falling serial clock edge
  logic [1:0] pos_slot0;  // captured data pins, rising edge, slot 0
  logic [1:0] pos_slot1;  // captured data pins, rising edge, slot 1
  logic [1:0] neg_slot0;  // captured data pins, falling edge, slot 0
  logic [1:0] neg_slot1;  // captured data pins, falling edge, slot 1
  logic [1:0] tgl_s;      // synchronised toggles {neg, pos}
  logic [1:0] tgl_prev_q; // toggles seen last cycle
  logic [1:0] din_s;      // synchronised data pins {pa, pb}

  // inputs are captured whatever the wire mode is
  usu_edge_capture u_capture (
    .link_clk  (link_clk),
    .reset     (reset),
    .din       ({pa_in[`USU_PIN_DI], pb_in[`USU_PIN_DI]}),
    .pos_tgl   (pos_tgl),
    .neg_tgl   (neg_tgl),
    .pos_slot0 (pos_slot0),
    .pos_slot1 (pos_slot1),
    .neg_slot0 (neg_slot0),
    .neg_slot1 (neg_slot1)
  );

  // toggles cross as levels; the slot they name is stable by then
  usu_sync3 #(.WIDTH(2)) u_sync_tgl (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({neg_tgl, pos_tgl}),
    .sync_out (tgl_s)
  );

  // data pins for the software and timer sources
  usu_sync3 #(.WIDTH(2)) u_sync_din (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({pa_in[`USU_PIN_DI], pb_in[`USU_PIN_DI]}),
    .sync_out (din_s)
  );

  // remember toggles to spot each crossed edge once
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tgl_prev_q <= 2'b00;
    end else begin
      tgl_prev_q <= tgl_s;
    end
  end

  logic       pos_evt;  // a rising serial clock edge arrived
  logic       neg_evt;  // a falling serial clock edge arrived
  logic [1:0] pos_bits; // pins sampled at that rising edge
  logic [1:0] neg_bits; // pins sampled at that falling edge
  logic       gsel;     // group index inside the {pa, pb} pairs
  assign pos_evt  = tgl_s[0] ^ tgl_prev_q[0];
  assign neg_evt  = tgl_s[1] ^ tgl_prev_q[1];
  // the slot written last is the one named by the old toggle value
  assign pos_bits = tgl_prev_q[0] ? pos_slot1 : pos_slot0;
  assign neg_bits = tgl_prev_q[1] ? neg_slot1 : neg_slot0;
  assign gsel     = pin_pos_sel_q;

  // ---------------- clock source selection ----------------
  logic shift_en;  // shift register clock this cycle
  logic shift_bit; // bit entering the shift register
  logic latch_en;  // external output latch update
  logic [1:0] cnt_inc; // counter steps this cycle, both edges can coincide

  always_comb begin
    shift_en  = 1'b0;
    shift_bit = din_prev_q;
    latch_en  = 1'b0;
    cnt_inc   = 2'h0;
    case (src)
      USU_SRC_SOFT: begin
        // a strobe shifts once and counts once
        shift_en  = strobe_wr;
        shift_bit = din_prev_q;
        cnt_inc   = {1'b0, strobe_wr};
      end
      USU_SRC_TIMER: begin
        // timer match clocks both, the strobe bit plays no part
        shift_en  = timer_match;
        shift_bit = din_prev_q;
        cnt_inc   = {1'b0, timer_match};
      end
      USU_SRC_EXT_POS: begin
        shift_en  = pos_evt;
        shift_bit = pos_bits[gsel];
        latch_en  = neg_evt;
      end
      USU_SRC_EXT_NEG: begin
        shift_en  = neg_evt;
        shift_bit = neg_bits[gsel];
        latch_en  = pos_evt;
      end
      default: begin
        shift_en  = 1'b0;
      end
    endcase
    if (ext) begin
      if (clk_strobe_q) begin
        cnt_inc = {1'b0, toggle_wr};
      end else begin
        cnt_inc = {1'b0, pos_evt} + {1'b0, neg_evt};
      end
    end
  end

  // input one cycle back, so a strobe shifts the older sample
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      din_prev_q <= 1'b0;
    end else begin
      din_prev_q <= din_s[gsel];
    end
  end

  // ---------------- control registers ----------------
  // strobe and toggle bits are not held as readable state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clk_src_sel_q   <= 2'b00;
      clk_strobe_q    <= 1'b0;
      wire_mode_sel_q <= 2'b00;
      clk_dir_q       <= 1'b0;
      do_dir_q        <= 1'b0;
    end else if (wr_ctrl) begin
      clk_src_sel_q   <= wbyte[`USU_CTRL_SRC_HI:`USU_CTRL_SRC_LO];
      clk_strobe_q    <= wbyte[`USU_CTRL_STROBE];
      wire_mode_sel_q <= wbyte[`USU_CTRL_WM_HI:`USU_CTRL_WM_LO];
      clk_dir_q       <= wbyte[`USU_CTRL_CLK_DIR];
      do_dir_q        <= wbyte[`USU_CTRL_DO_DIR];
    end
  end

  // pin group select, port B after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_pos_sel_q <= `USU_RST_PINPOS;
    end else if (wr_pinpos) begin
      pin_pos_sel_q <= wbyte[`USU_PINPOS_SEL];
    end
  end

  // clock port inverts on each toggle write, any direction
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clk_port_q <= 1'b0;
    end else if (toggle_wr) begin
      clk_port_q <= ~clk_port_q;
    end
  end

  // ---------------- shift register and counter ----------------
  // a software write wins over a shift in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      data_q <= `USU_RST_DATA;
    end else if (wr_data) begin
      data_q <= wbyte[DATA_W-1:0];
    end else if (shift_en) begin
      data_q <= {data_q[DATA_W-2:0], shift_bit};
    end
  end

  logic [CNT_W:0] cnt_sum; // counter plus steps, carry in top bit
  assign cnt_sum = {1'b0, count_q} + {{(CNT_W-1){1'b0}}, cnt_inc};

  // counter wraps and raises the sticky flag
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else if (wr_count) begin
      count_q <= wbyte[CNT_W-1:0];
    end else begin
      count_q <= cnt_sum[CNT_W-1:0];
    end
  end

  // flag is cleared by writing one; a count write in the same cycle wins over a wrap
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ovf_q <= 1'b0;
    end else if (cnt_sum[CNT_W] && !wr_count) begin
      ovf_q <= 1'b1;
    end else if (wr_count && wbyte[`USU_CNT_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  // external mode: output moves only on the edge opposite sampling
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_latch_q <= 1'b0;
    end else if (latch_en || !ext) begin
      out_latch_q <= data_q[DATA_W-1];
    end
  end

  // transparent latch for software and timer sources
  logic dout;  // data output bit
  assign dout = ext ? out_latch_q : data_q[DATA_W-1];

  // ---------------- output stage ----------------
  // wire mode shapes only the drivers
  usu_wm_type wm;
  assign wm = usu_wm_type'(wire_mode_sel_q);

  logic [2:0] grp_out; // pin values of the selected group
  logic [2:0] grp_oe;  // pin enables of the selected group

  always_comb begin
    grp_out = 3'b000;
    grp_oe  = 3'b000;
    // clock pin shows the port value only when set as output
    grp_out[`USU_PIN_CLK] = clk_port_q;
    grp_oe[`USU_PIN_CLK]  = clk_dir_q;
    case (wm)
      USU_WM_THREE: begin
        grp_out[`USU_PIN_DO] = dout;
        grp_oe[`USU_PIN_DO]  = do_dir_q;
      end
      USU_WM_TWO, USU_WM_TWO_HOLD: begin
        // open drain: only ever pull low
        grp_out[`USU_PIN_DI]  = 1'b0;
        grp_oe[`USU_PIN_DI]   = do_dir_q & ~dout;
        grp_out[`USU_PIN_CLK] = 1'b0;
        grp_oe[`USU_PIN_CLK]  = clk_dir_q & ~clk_port_q;
      end
      USU_WM_OFF: begin
        grp_oe[`USU_PIN_DO] = 1'b0;
      end
      default: begin
        grp_oe = 3'b000;
      end
    endcase
  end

  // route the group to port A or port B, the other stays released
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pa_out <= 3'b000;
      pa_oe  <= 3'b000;
      pb_out <= 3'b000;
      pb_oe  <= 3'b000;
    end else begin
      pa_out <= pin_pos_sel_q ? grp_out : 3'b000;
      pa_oe  <= pin_pos_sel_q ? grp_oe  : 3'b000;
      pb_out <= pin_pos_sel_q ? 3'b000  : grp_out;
      pb_oe  <= pin_pos_sel_q ? 3'b000  : grp_oe;
    end
  end

  // ---------------- bus answer ----------------
  // one wait state: ack rises the cycle after the request, then drops
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req & ~ack_q;
    end
  end

  logic [7:0] rd_byte; // readback of the addressed register
  always_comb begin
    case (wb_adr_i)
      // strobe and toggle positions always read zero
      `USU_OFS_CTRL:   rd_byte = {do_dir_q, clk_dir_q, wire_mode_sel_q,
                                  clk_src_sel_q, 2'b00};
      `USU_OFS_DATA:   rd_byte = data_q;
      `USU_OFS_COUNT:  rd_byte = {ovf_q, 3'b000, count_q};
      `USU_OFS_PINPOS: rd_byte = {7'h00, pin_pos_sel_q};
      default:         rd_byte = 8'h00;  // unmapped reads zero
    endcase
  end

  // read data is registered as the ack is raised
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !ack_q) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule : usu_shift_clock
`default_nettype wire

//--- usu_consts.svh
// register map, field positions and reset values of the serial shift unit
`ifndef USU_CONSTS_SVH
`define USU_CONSTS_SVH

// register byte offsets on the bus
`define USU_OFS_CTRL    8'h00
`define USU_OFS_DATA    8'h04
`define USU_OFS_COUNT   8'h08
`define USU_OFS_PINPOS  8'h0c

// control register fields
`define USU_CTRL_TOGGLE   0
`define USU_CTRL_STROBE   1
`define USU_CTRL_SRC_LO   2
`define USU_CTRL_SRC_HI   3
`define USU_CTRL_WM_LO    4
`define USU_CTRL_WM_HI    5
`define USU_CTRL_CLK_DIR  6
`define USU_CTRL_DO_DIR   7

// count register fields
`define USU_CNT_OVF       7

// pin position register field
`define USU_PINPOS_SEL    0

// reset values
`define USU_RST_CTRL      8'h00
`define USU_RST_DATA      8'h00
`define USU_RST_PINPOS    1'b0

// pin indices inside a pin group
`define USU_PIN_DI        0
`define USU_PIN_DO        1
`define USU_PIN_CLK       2

`endif

//--- usu_pkg.sv
// types shared by the serial shift unit
package usu_pkg;

  // decoded clock source of the data register
  typedef enum logic [2:0] {
    USU_SRC_NONE,
    USU_SRC_SOFT,
    USU_SRC_TIMER,
    USU_SRC_EXT_POS,
    USU_SRC_EXT_NEG
  } usu_src_type;

  // output stage behaviour chosen by the wire mode field
  typedef enum logic [1:0] {
    USU_WM_OFF,
    USU_WM_THREE,
    USU_WM_TWO,
    USU_WM_TWO_HOLD
  } usu_wm_type;

endpackage : usu_pkg

//--- usu_sync3.sv
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module usu_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;  // metastability catcher, read only by s2
  logic [WIDTH-1:0] s2_q;  // second stage
  logic [WIDTH-1:0] s3_q;  // third stage

  // shift chain
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per-bit agreement filter, so a lone glitch in stage two never counts
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          sync_out[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule : usu_sync3
`default_nettype wire

//--- usu_edge_capture.sv
// link-side capture of the data inputs on both edges of the serial clock
`timescale 1ns/10ps
`default_nettype none
module usu_edge_capture (
  input  wire logic       link_clk,
  input  wire logic       reset,
  input  wire logic [1:0] din,
  output logic            pos_tgl,
  output logic            neg_tgl,
  output logic [1:0]      pos_slot0,
  output logic [1:0]      pos_slot1,
  output logic [1:0]      neg_slot0,
  output logic [1:0]      neg_slot1
);

  // rising edge: store both data pins in the slot named by the toggle,
  // then flip it; two slots give the system side a full period to read
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      pos_tgl   <= 1'b0;
      pos_slot0 <= 2'b00;
      pos_slot1 <= 2'b00;
    end else begin
      if (pos_tgl) begin
        pos_slot1 <= din;
      end else begin
        pos_slot0 <= din;
      end
      pos_tgl <= ~pos_tgl;
    end
  end

  // falling edge: same scheme on the opposite edge
  always_ff @(negedge link_clk or posedge reset) begin
    if (reset) begin
      neg_tgl   <= 1'b0;
      neg_slot0 <= 2'b00;
      neg_slot1 <= 2'b00;
    end else begin
      if (neg_tgl) begin
        neg_slot1 <= din;
      end else begin
        neg_slot0 <= din;
      end
      neg_tgl <= ~neg_tgl;
    end
  end

endmodule : usu_edge_capture
`default_nettype wire

//--- usu_shift_clock_sva.sv
// bus and pin port assertions for the shift clock select block
`include "usu_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module usu_shift_clock_sva (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  pa_oe,
  input wire logic [2:0]  pb_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic rd_ack;  // read completing in this cycle
  logic mapped;  // address hits one of the four registers
  // master holds address and direction through the ack cycle
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign mapped = wb_adr_i inside {`USU_OFS_CTRL, `USU_OFS_DATA,
                                   `USU_OFS_COUNT, `USU_OFS_PINPOS};
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  AST_STROBE_RD0: assert property (
    rd_ack && wb_adr_i == `USU_OFS_CTRL |-> wb_dat_o[1:0] == 2'h0)
    else $error("strobe or toggle bit read back as one");
  AST_PINPOS_RSV: assert property (
    rd_ack && wb_adr_i == `USU_OFS_PINPOS |-> wb_dat_o[7:1] == 7'h0)
    else $error("reserved pin position bits not zero");
  AST_UNMAPPED: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_ONE_GROUP: assert property (!((|pa_oe) && (|pb_oe)))
    else $error("both pin groups driven");
  AST_RST_QUIET: assert property (
    $fell(reset) |-> pa_oe == 3'h0 && pb_oe == 3'h0 && !wb_ack_o)
    else $error("outputs active after reset");
  // main scenarios reached
  COV_CTRL_RD: cover property (rd_ack && wb_adr_i == `USU_OFS_CTRL);
  COV_PA_DRIVE: cover property (|pa_oe);
  COV_PB_DRIVE: cover property (|pb_oe);
endmodule : usu_shift_clock_sva
`default_nettype wire

//--- usu_peer.sv
// behavioural serial peer: link clock and data line toward the unit
`timescale 1ns/10ps
`default_nettype none
module usu_peer (
  output logic link_clk,  // stands low outside frames
  output logic din        // data line toward the unit
);
  initial begin
    link_clk = 1'b0;
    din      = 1'b0;
  end
  // level for software or timer clocked shifts, changed on the nba region
  task hold(input logic v);
    din <= v;
  endtask : hold
  // n bits msb first, one 7.5 ns clock pulse each; the line flips between
  // the two edges, so rising and falling edges see opposite values.
  // the clock then rests low, so edges of one kind sit 60 ns apart: the
  // unit's three-stage crossing needs about five system cycles per edge
  task send(input logic [7:0] bits, input int n);
    #1;
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      #3.75 link_clk = 1'b1;
      #3.75 din = ~bits[i];
      #3.75 link_clk = 1'b0;
      #48.75;
    end
    din = ~din;  // released line never keeps its last value
  endtask : send
endmodule : usu_peer
`default_nettype wire

//--- usu_shift_clock_tb.sv
// self-checking bench for the shift clock select block
`include "usu_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module usu_shift_clock_tb;
  logic        clk_sys;      // system clock, 8 ns
  logic        reset;        // async reset, active high
  logic        cyc, stb, we; // bus request
  logic [7:0]  adr;          // byte address
  logic [31:0] wdat;         // write data, lane 0 used
  logic [3:0]  sel;          // byte select
  logic        timer_match;  // timer compare pulse
  logic        link_clk;     // peer serial clock
  logic        din;          // peer data line
  logic [31:0] wb_dat_o;     // read data
  logic        wb_ack_o;     // bus answer
  logic [2:0]  pa_out, pa_oe, pb_out, pb_oe;  // pin drive
  logic [7:0]  rd;           // last byte read
  int          err_total, checks_done, cycles;

  usu_shift_clock dut (
    .clk_sys(clk_sys), .reset(reset), .link_clk(link_clk),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_match(timer_match),
    .pa_in({link_clk, pa_out[1], din}), .pb_in({link_clk, pb_out[1], din}),
    .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe)
  );
  usu_peer peer (.link_clk(link_clk), .din(din));

  always #4 clk_sys = ~clk_sys;

  // cycle ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // classic cycle: hold everything until ack is sampled high
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    sel  <= 4'h1;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask : rdc

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    {cyc, stb, we, timer_match} = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    {err_total, checks_done, cycles} = 0;
    tick(16);
    reset <= 1'b0;
    // reset values and an unmapped address
    rdc(`USU_OFS_CTRL, `USU_RST_CTRL);
    rdc(`USU_OFS_DATA, `USU_RST_DATA);
    rdc(`USU_OFS_PINPOS, 8'h00);
    rdc(8'h10, 8'h00);
    // software strobe, three-wire with data out driven on port b
    wr(`USU_OFS_DATA, 8'h81);
    peer.hold(1'b1);
    wr(`USU_OFS_CTRL, 8'h90);
    tick(4);
    chk({6'h0, pb_oe[1], pb_out[1]}, 8'h03);
    rdc(`USU_OFS_COUNT, 8'h00);
    wr(`USU_OFS_CTRL, 8'h92);
    tick(2);
    chk({6'h0, pb_oe[1], pb_out[1]}, 8'h02);
    rdc(`USU_OFS_DATA, 8'h03);
    rdc(`USU_OFS_COUNT, 8'h01);
    rdc(`USU_OFS_CTRL, 8'h90);
    // timer source: strobe bit has no effect, a match clocks both
    peer.hold(1'b0);
    // enter timer source first, so the strobe write below meets it
    wr(`USU_OFS_CTRL, 8'h04);
    wr(`USU_OFS_CTRL, 8'h06);
    tick(4);
    rdc(`USU_OFS_COUNT, 8'h01);
    @(posedge clk_sys) timer_match <= 1'b1;
    @(posedge clk_sys) timer_match <= 1'b0;
    tick(2);
    rdc(`USU_OFS_DATA, 8'h06);
    rdc(`USU_OFS_COUNT, 8'h02);
    // external clock, rising then falling edge, outputs off
    for (int i = 0; i < 2; i++) begin
      wr(`USU_OFS_CTRL, (i != 0) ? 8'h0c : 8'h08);
      wr(`USU_OFS_COUNT, 8'h80);
      wr(`USU_OFS_DATA, 8'h00);
      peer.send(8'h05, 3);
      tick(10);
      rdc(`USU_OFS_DATA, (i != 0) ? 8'h02 : 8'h05);
      rdc(`USU_OFS_COUNT, 8'h06);
    end
    // external shift, counter clocked by toggle writes only
    wr(`USU_OFS_CTRL, 8'h0a);
    wr(`USU_OFS_COUNT, 8'h8e);
    peer.send(8'h07, 3);
    tick(10);
    rdc(`USU_OFS_COUNT, 8'h0e);
    wr(`USU_OFS_CTRL, 8'h0b);
    wr(`USU_OFS_CTRL, 8'h0b);
    tick(2);
    // two toggle writes step 14 to 15 and wrap to 0, raising the flag
    rdc(`USU_OFS_COUNT, 8'h80);
    rdc(`USU_OFS_DATA, 8'h17);
    // clock port toggles, shown once its direction is output
    wr(`USU_OFS_CTRL, 8'h50);
    wr(`USU_OFS_CTRL, 8'h51);
    tick(2);
    chk({6'h0, pb_oe[2], pb_out[2]}, 8'h03);
    wr(`USU_OFS_PINPOS, 8'hff);
    rdc(`USU_OFS_PINPOS, 8'h01);
    wr(`USU_OFS_CTRL, 8'h51);
    tick(2);
    chk({2'h0, pa_oe[2], pa_out[2], 1'b0, pb_oe}, 8'h20);
    end_of_test();
  end
endmodule : usu_shift_clock_tb

bind usu_shift_clock usu_shift_clock_sva sva_i (
  .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pa_oe(pa_oe), .pb_oe(pb_oe)
);
`default_nettype wire
